//--- include/sccr_pkg.sv
/*
  Constants for the socket card control register pair: offsets, bit
  positions, reset values and mode codes.
  Assumes a byte-wide configuration access port for functions 0 and 1.
*/
// Operation
// - Ring output enable bit 7 drives ring-indicate output; resets to 0.
// - Global bits held once, shared by both functions, written via function 0.
// - Video-port float enable bit 6 floats that socket's video terminals.
// - Both floating: priority bit 5 picks socket 0 or socket 1 select.
// - Audio-to-multifunction bit 2 routes card audio to multifunction terminal.
// - Both sockets routing audio: socket 0 wins the multifunction terminal.
// - Speaker enable bit 1 routes speaker inputs, XORed across sockets.
// - Speaker output driven only while some function's speaker enable is set.
// - Card interrupt flag bit 0 set on that socket's functional interrupt.
// - Writing 1 clears card interrupt flag; writing 0 ignored; resets 0.
// - Card control bits 4 and 3 read 0.
// - Power lock bit 7 blocks socket power-down while function in D3.
// - Global 3-V force bit 6 reports 3-V capability; resets to 1.
// - Device control bit 5 is read/write diagnostic, resets to 1.
// - Device control bit 4 reads 0, writes ignored.
// - Interrupt mode bits 2:1 select signalling scheme; reset 11.
// - Device control at offset 92h in both functions, resets to 66h.
package sccr_pkg;
  localparam logic [7:0] CARD_CTRL_OFS   = 8'h91;
  localparam logic [7:0] DEV_CTRL_OFS    = 8'h92;
  localparam logic [7:0] DEV_CTRL_RST    = 8'h66;
  localparam logic [7:0] CARD_CTRL_RST   = 8'h00;
  localparam logic [7:0] READ_ZERO       = 8'h00;
  // Card control bits
  localparam int CC_RING_EN   = 7;
  localparam int CC_VID_FLOAT = 6;
  localparam int CC_PRIORITY  = 5;
  localparam int CC_AUD2MF    = 2;
  localparam int CC_SPK_EN    = 1;
  localparam int CC_IRQ_FLAG  = 0;
  // Device control bits
  localparam int DC_PWR_HOLD  = 7;
  localparam int DC_LV_FORCE  = 6;
  localparam int DC_DIAG      = 5;
  localparam int DC_TEST      = 3;
  localparam int DC_MODE_HI   = 2;
  localparam int DC_MODE_LO   = 1;
  localparam int DC_TEST0     = 0;
  // Interrupt signalling modes
  typedef enum logic [1:0]
  {
    SCCR_MODE_PARALLEL = 2'h0,
    SCCR_MODE_RSVD     = 2'h1,
    SCCR_MODE_SER_INTAB = 2'h2,
    SCCR_MODE_SERIAL   = 2'h3
  } sccr_mode_e;
endpackage : sccr_pkg

//--- hw/sccr_regs.sv
/*
  Card control and device control registers for two socket functions,
  with the socket-side routing they steer.
  Assumes configuration accesses and socket inputs synchronous to i_clk.
*/
`timescale 1ns/1ps
module sccr_regs
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  // Configuration access
  input  wire logic       i_cfg_wr,
  input  wire logic       i_cfg_rd,
  input  wire logic       i_cfg_func,
  input  wire logic [7:0] i_cfg_addr,
  input  wire logic [7:0] i_cfg_wdata,
  output logic      [7:0] o_cfg_rdata,
  output logic            o_cfg_ack,
  // Ring indicate
  input  wire logic       i_ring_source,
  output logic            o_ring_indicate_output,
  output logic            o_ring_indicate_output_oe,
  // Video port
  output logic      [1:0] o_video_port_float_enable,
  output logic            o_video_select_socket_a_n,
  output logic            o_video_select_socket_b_n,
  // Audio
  input  wire logic [1:0] i_card_audio_input,
  input  wire logic [1:0] i_card_speaker_input,
  output logic            o_multifunction_terminal,
  output logic            o_speaker_output,
  output logic            o_speaker_output_oe,
  // Card interrupts and power
  input  wire logic [1:0] i_card_func_irq,
  input  wire logic [1:0] i_func_in_d3,
  input  wire logic [1:0] i_power_down_req,
  output logic      [1:0] o_socket_power_down,
  // Global status
  output logic            o_low_voltage_capable,
  output logic      [1:0] o_intr_mode_f0,
  output logic      [1:0] o_intr_mode_f1
);

  logic       ring_en_q;
  logic [1:0] vid_float_q;
  logic [1:0] prio_q;
  logic [1:0] aud2mf_q;
  logic [1:0] spk_en_q;
  logic [1:0] irq_flag_q;
  logic [1:0] pwr_hold_q;
  logic [1:0] diag_q;
  logic [1:0] mode_hi_q;
  logic [1:0] mode_lo_q;
  logic       lv_force_q;
  logic       test_q;
  logic       test0_q;
  logic       cc_wr;
  logic       dc_wr;
  logic       glob_wr;
  logic [7:0] rd_d;

  assign cc_wr   = i_cfg_wr && (i_cfg_addr == sccr_pkg::CARD_CTRL_OFS);
  assign dc_wr   = i_cfg_wr && (i_cfg_addr == sccr_pkg::DEV_CTRL_OFS);
  assign glob_wr = !i_cfg_func;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      vid_float_q <= {2{sccr_pkg::CARD_CTRL_RST[sccr_pkg::CC_VID_FLOAT]}};
      prio_q      <= {2{sccr_pkg::CARD_CTRL_RST[sccr_pkg::CC_PRIORITY]}};
    end
    else if (cc_wr)
    begin
      vid_float_q[i_cfg_func] <= i_cfg_wdata[sccr_pkg::CC_VID_FLOAT];
      prio_q[i_cfg_func]      <= i_cfg_wdata[sccr_pkg::CC_PRIORITY];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      aud2mf_q <= {2{sccr_pkg::CARD_CTRL_RST[sccr_pkg::CC_AUD2MF]}};
    else if (cc_wr)
      aud2mf_q[i_cfg_func] <= i_cfg_wdata[sccr_pkg::CC_AUD2MF];
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      spk_en_q <= {2{sccr_pkg::CARD_CTRL_RST[sccr_pkg::CC_SPK_EN]}};
    else if (cc_wr)
      spk_en_q[i_cfg_func] <= i_cfg_wdata[sccr_pkg::CC_SPK_EN];
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      ring_en_q <= sccr_pkg::CARD_CTRL_RST[sccr_pkg::CC_RING_EN];
    else if (cc_wr && glob_wr)
      ring_en_q <= i_cfg_wdata[sccr_pkg::CC_RING_EN];
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      irq_flag_q <= 2'h0;
    else
    begin
      for (int s = 0; s < 2; s++)
      begin
        if (i_card_func_irq[s])
          irq_flag_q[s] <= 1'b1;
        else if (cc_wr && (i_cfg_func == s[0]) && i_cfg_wdata[sccr_pkg::CC_IRQ_FLAG])
          irq_flag_q[s] <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      pwr_hold_q <= {2{sccr_pkg::DEV_CTRL_RST[sccr_pkg::DC_PWR_HOLD]}};
    else if (dc_wr)
      pwr_hold_q[i_cfg_func] <= i_cfg_wdata[sccr_pkg::DC_PWR_HOLD];
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      diag_q <= {2{sccr_pkg::DEV_CTRL_RST[sccr_pkg::DC_DIAG]}};
    else if (dc_wr)
      diag_q[i_cfg_func] <= i_cfg_wdata[sccr_pkg::DC_DIAG];
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      mode_hi_q <= {2{sccr_pkg::DEV_CTRL_RST[sccr_pkg::DC_MODE_HI]}};
      mode_lo_q <= {2{sccr_pkg::DEV_CTRL_RST[sccr_pkg::DC_MODE_LO]}};
    end
    else if (dc_wr)
    begin
      mode_hi_q[i_cfg_func] <= i_cfg_wdata[sccr_pkg::DC_MODE_HI];
      mode_lo_q[i_cfg_func] <= i_cfg_wdata[sccr_pkg::DC_MODE_LO];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      lv_force_q <= sccr_pkg::DEV_CTRL_RST[sccr_pkg::DC_LV_FORCE];
      test_q     <= sccr_pkg::DEV_CTRL_RST[sccr_pkg::DC_TEST];
      test0_q    <= sccr_pkg::DEV_CTRL_RST[sccr_pkg::DC_TEST0];
    end
    else if (dc_wr && glob_wr)
    begin
      lv_force_q <= i_cfg_wdata[sccr_pkg::DC_LV_FORCE];
      test_q     <= i_cfg_wdata[sccr_pkg::DC_TEST];
      test0_q    <= i_cfg_wdata[sccr_pkg::DC_TEST0];
    end
  end

  // Read mux; reserved bits stay zero
  always_comb
  begin
    rd_d = sccr_pkg::READ_ZERO;
    if (i_cfg_addr == sccr_pkg::CARD_CTRL_OFS)
    begin
      rd_d[sccr_pkg::CC_RING_EN]   = ring_en_q;
      rd_d[sccr_pkg::CC_VID_FLOAT] = vid_float_q[i_cfg_func];
      rd_d[sccr_pkg::CC_PRIORITY]  = prio_q[i_cfg_func];
      // Bits 4 and 3 read zero
      rd_d[sccr_pkg::CC_AUD2MF]    = aud2mf_q[i_cfg_func];
      rd_d[sccr_pkg::CC_SPK_EN]    = spk_en_q[i_cfg_func];
      rd_d[sccr_pkg::CC_IRQ_FLAG]  = irq_flag_q[i_cfg_func];
    end
    else if (i_cfg_addr == sccr_pkg::DEV_CTRL_OFS)
    begin
      rd_d[sccr_pkg::DC_PWR_HOLD]  = pwr_hold_q[i_cfg_func];
      rd_d[sccr_pkg::DC_LV_FORCE]  = lv_force_q;
      rd_d[sccr_pkg::DC_DIAG]      = diag_q[i_cfg_func];
      rd_d[sccr_pkg::DC_TEST]      = test_q;
      rd_d[sccr_pkg::DC_MODE_HI]   = mode_hi_q[i_cfg_func];
      rd_d[sccr_pkg::DC_MODE_LO]   = mode_lo_q[i_cfg_func];
      rd_d[sccr_pkg::DC_TEST0]     = test0_q;
    end
  end

  // Unmapped offsets read zero but are still acknowledged
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_cfg_rdata <= sccr_pkg::READ_ZERO;
      o_cfg_ack   <= 1'b0;
    end
    else
    begin
      o_cfg_ack <= i_cfg_rd || i_cfg_wr;
      if (i_cfg_rd)
        o_cfg_rdata <= rd_d;
    end
  end

  // Socket-side outputs, registered
  // Ring output gated
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_ring_indicate_output    <= 1'b0;
      o_ring_indicate_output_oe <= 1'b0;
    end
    else
    begin
      o_ring_indicate_output    <= ring_en_q & i_ring_source;
      o_ring_indicate_output_oe <= ring_en_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_video_port_float_enable <= 2'h0;
      o_video_select_socket_a_n <= 1'b1;
      o_video_select_socket_b_n <= 1'b1;
    end
    else
    begin
      o_video_port_float_enable <= vid_float_q;
      if (&vid_float_q)
      begin
        o_video_select_socket_a_n <= prio_q[0];
        o_video_select_socket_b_n <= !prio_q[0];
      end
      else
      begin
        o_video_select_socket_a_n <= !vid_float_q[0];
        o_video_select_socket_b_n <= !vid_float_q[1];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_multifunction_terminal <= 1'b0;
    else if (aud2mf_q[0])
      o_multifunction_terminal <= i_card_audio_input[0];
    else if (aud2mf_q[1])
      o_multifunction_terminal <= i_card_audio_input[1];
    else
      o_multifunction_terminal <= 1'b0;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_speaker_output    <= 1'b0;
      o_speaker_output_oe <= 1'b0;
    end
    else
    begin
      o_speaker_output <=
        (spk_en_q[0] & (i_card_speaker_input[0] ^ (i_card_audio_input[0] & !aud2mf_q[0]))) ^
        (spk_en_q[1] & (i_card_speaker_input[1] ^ (i_card_audio_input[1] & !aud2mf_q[1])));
      o_speaker_output_oe <= |spk_en_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_socket_power_down <= 2'h0;
    else
      o_socket_power_down <= i_power_down_req & ~(pwr_hold_q & i_func_in_d3);
  end

  assign o_low_voltage_capable = lv_force_q;
  assign o_intr_mode_f0        = {mode_hi_q[0], mode_lo_q[0]};
  assign o_intr_mode_f1        = {mode_hi_q[1], mode_lo_q[1]};

endmodule : sccr_regs

//--- verification/sccr_regs_props.sv
/* Checker for the card and device control registers.
   Bound to sccr_regs; sees only its ports. */
`timescale 1ns/1ps
module sccr_regs_props
(
  // Watched ports
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic       i_cfg_wr,
  input wire logic       i_cfg_rd,
  input wire logic       i_cfg_func,
  input wire logic [7:0] i_cfg_addr,
  input wire logic [7:0] o_cfg_rdata,
  input wire logic       o_cfg_ack,
  input wire logic       o_ring_indicate_output,
  input wire logic       o_ring_indicate_output_oe,
  input wire logic [1:0] o_video_port_float_enable,
  input wire logic       o_video_select_socket_a_n,
  input wire logic       o_video_select_socket_b_n,
  input wire logic       o_speaker_output,
  input wire logic       o_speaker_output_oe,
  input wire logic [1:0] i_func_in_d3,
  input wire logic [1:0] i_power_down_req,
  input wire logic [1:0] o_socket_power_down,
  input wire logic       o_low_voltage_capable
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence lone_access;
    (i_cfg_wr || i_cfg_rd) ##1 !(i_cfg_wr || i_cfg_rd);
  endsequence
  sequence rd_at(logic [7:0] a);
    i_cfg_rd && i_cfg_addr == a ##1 o_cfg_ack;
  endsequence
  AST_ACK_ONE: assert property (lone_access |-> o_cfg_ack ##1 !o_cfg_ack)
    else $error("ack not a single cycle after access");
  AST_ACK_CAUSE: assert property (o_cfg_ack |-> $past(i_cfg_wr || i_cfg_rd))
    else $error("ack without access");
  AST_RING_GATED: assert property (o_ring_indicate_output |-> o_ring_indicate_output_oe)
    else $error("ring output while disabled");
  AST_SPK_DRIVEN: assert property (o_speaker_output |-> o_speaker_output_oe)
    else $error("speaker data while not driven");
  AST_SEL_EXCL: assert property (o_video_select_socket_a_n || o_video_select_socket_b_n)
    else $error("both video selects asserted");
  AST_SEL_FLOAT: assert property (!o_video_select_socket_b_n |-> o_video_port_float_enable[1])
    else $error("select without float");
  AST_PWR_PASS: assert property (i_power_down_req[1] && !i_func_in_d3[1] |=> o_socket_power_down[1])
    else $error("power down outside D3 lost");
  AST_LV_WRITE: assert property (!$stable(o_low_voltage_capable) |->
    $past(i_cfg_wr && !i_cfg_func && i_cfg_addr == 8'h92))
    else $error("3-V flag moved without function 0 write");
  AST_RSV_CARD: assert property (rd_at(8'h91) |-> o_cfg_rdata[4:3] == 2'h0)
    else $error("card control reserved bits set");
  AST_RSV_DEV: assert property (rd_at(8'h92) |-> !o_cfg_rdata[4])
    else $error("device control bit 4 set");
endmodule : sccr_regs_props
bind sccr_regs sccr_regs_props i_sccr_regs_props (.i_clk, .i_rstn, .i_cfg_wr, .i_cfg_rd,
  .i_cfg_func, .i_cfg_addr, .o_cfg_rdata, .o_cfg_ack, .o_ring_indicate_output,
  .o_ring_indicate_output_oe, .o_video_port_float_enable, .o_video_select_socket_a_n,
  .o_video_select_socket_b_n, .o_speaker_output, .o_speaker_output_oe, .i_func_in_d3,
  .i_power_down_req, .o_socket_power_down, .o_low_voltage_capable);

//--- verification/sccr_socket_model.sv
/* Card side of both sockets: interrupt, speaker and audio levels.
   Commanded by the bench; changes only on the falling edge. */
`timescale 1ns/1ps
module sccr_socket_model
(
  // Clock and commands
  input  wire logic       i_clk,
  input  wire logic [1:0] i_irq_kick,
  input  wire logic [1:0] i_spk_lvl,
  input  wire logic [1:0] i_aud_lvl,
  // Card signals
  output logic      [1:0] o_card_func_irq,
  output logic      [1:0] o_card_speaker_input,
  output logic      [1:0] o_card_audio_input
);
  initial {o_card_func_irq, o_card_speaker_input, o_card_audio_input} = 6'h00;
  always @(negedge i_clk)
  begin
    o_card_func_irq      <= i_irq_kick;
    o_card_speaker_input <= i_spk_lvl;
    o_card_audio_input   <= i_aud_lvl;
  end
endmodule : sccr_socket_model

//--- verification/tb.sv
/* Bench for sccr_regs: access table, then routing, flag, power and reset.
   Assumes one 40 MHz clock; inputs change on the falling edge. */
`timescale 1ns/1ps
module tb;
  logic i_clk, i_rstn, i_cfg_wr, i_cfg_rd, i_cfg_func, i_ring_source, o_cfg_ack;
  logic [7:0] i_cfg_addr, i_cfg_wdata, o_cfg_rdata;
  logic [1:0] i_func_in_d3, i_power_down_req, irq_kick, spk_lvl, aud_lvl;
  logic [1:0] i_card_audio_input, i_card_speaker_input, i_card_func_irq;
  logic [1:0] o_video_port_float_enable, o_socket_power_down, o_intr_mode_f0, o_intr_mode_f1;
  logic o_ring_indicate_output, o_ring_indicate_output_oe, o_video_select_socket_a_n;
  logic o_video_select_socket_b_n, o_multifunction_terminal, o_speaker_output;
  logic o_speaker_output_oe, o_low_voltage_capable;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  // Nibble: 8 write f0, C write f1, 0 read f0, 4 read f1; then offset, data
  // Test bits written 0
  logic [19:0] rows [15] = '{20'h892F6, 20'h092E6, 20'h49266, 20'hC9200, 20'h49240,
    20'h092E6, 20'h891FF, 20'h091E6, 20'h49180, 20'h05500, 20'h89260, 20'h89262,
    20'h89264, 20'h09264, 20'h892E6};
  sccr_regs i_sccr_regs (.i_clk, .i_rstn, .i_cfg_wr, .i_cfg_rd, .i_cfg_func, .i_cfg_addr,
    .i_cfg_wdata, .o_cfg_rdata, .o_cfg_ack, .i_ring_source, .o_ring_indicate_output,
    .o_ring_indicate_output_oe, .o_video_port_float_enable, .o_video_select_socket_a_n,
    .o_video_select_socket_b_n, .i_card_audio_input, .i_card_speaker_input,
    .o_multifunction_terminal, .o_speaker_output, .o_speaker_output_oe, .i_card_func_irq,
    .i_func_in_d3, .i_power_down_req, .o_socket_power_down, .o_low_voltage_capable,
    .o_intr_mode_f0, .o_intr_mode_f1);
  sccr_socket_model i_sccr_socket_model (.i_clk, .i_irq_kick(irq_kick), .i_spk_lvl(spk_lvl),
    .i_aud_lvl(aud_lvl), .o_card_func_irq(i_card_func_irq),
    .o_card_speaker_input(i_card_speaker_input), .o_card_audio_input(i_card_audio_input));
  initial
  begin
    i_clk = 1'h0;
    forever #12.5 i_clk = ~i_clk;
  end
  task complete_run;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  // Ceiling well above the roughly 100 cycles the sequence needs
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      complete_run;
    end
  end
  task chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task step(input int n);
    repeat (n) @(negedge i_clk);
  endtask : step
  task acc(input logic w, input logic f, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    {i_cfg_wr, i_cfg_rd, i_cfg_func} = {w, !w, f};
    {i_cfg_addr, i_cfg_wdata} = {a, d};
    @(negedge i_clk);
    {i_cfg_wr, i_cfg_rd} = 2'h0;
    chk(o_cfg_ack, 8'h01);
    if (!w)
      chk(o_cfg_rdata, d);
  endtask : acc
  initial
  begin
    {i_rstn, i_cfg_wr, i_cfg_rd, i_cfg_func, i_ring_source} = 5'h00;
    {i_cfg_addr, i_cfg_wdata, i_func_in_d3, i_power_down_req} = 20'h00000;
    {irq_kick, spk_lvl, aud_lvl} = 6'h00;
    step(6);
    i_rstn = 1'h1;
    foreach (rows[k])
    begin
      acc(rows[k][19], rows[k][18], rows[k][15:8], rows[k][7:0]);
      step(1);
      if (rows[k][19] && rows[k][15:8] == 8'h92)
        chk(rows[k][18] ? o_intr_mode_f1 : o_intr_mode_f0, rows[k][2:1]);
    end
    $display("Test done: access table");
    chk({o_video_select_socket_a_n, o_video_select_socket_b_n}, 8'h01);
    i_ring_source = 1'h1;
    spk_lvl <= 2'h1;
    acc(1'h1, 1'h1, 8'h91, 8'h46);
    step(2);
    chk({o_ring_indicate_output, o_ring_indicate_output_oe}, 8'h03);
    chk({o_video_select_socket_a_n, o_video_select_socket_b_n}, 8'h02);
    chk({o_speaker_output_oe, o_speaker_output}, 8'h03);
    chk(o_video_port_float_enable, 8'h03);
    spk_lvl <= 2'h3;
    aud_lvl <= 2'h2;
    step(3);
    chk({o_speaker_output, o_multifunction_terminal}, 8'h00);
    aud_lvl <= 2'h1;
    step(3);
    chk(o_multifunction_terminal, 8'h01);
    $display("Test done: socket routing");
    irq_kick <= 2'h1;
    step(1);
    irq_kick <= 2'h0;
    step(2);
    acc(1'h0, 1'h0, 8'h91, 8'hE7);
    acc(1'h0, 1'h1, 8'h91, 8'hC6);
    acc(1'h1, 1'h0, 8'h91, 8'hE6);
    acc(1'h0, 1'h0, 8'h91, 8'hE7);
    acc(1'h1, 1'h0, 8'h91, 8'hE7);
    acc(1'h0, 1'h0, 8'h91, 8'hE6);
    $display("Test done: interrupt flag");
    acc(1'h1, 1'h0, 8'h91, 8'hC0);
    acc(1'h1, 1'h1, 8'h91, 8'h40);
    step(2);
    chk({o_video_select_socket_a_n, o_video_select_socket_b_n}, 8'h01);
    chk(o_speaker_output_oe, 8'h00);
    {i_func_in_d3, i_power_down_req} = 4'h7;
    step(2);
    chk(o_socket_power_down, 8'h02);
    i_func_in_d3 = 2'h0;
    step(2);
    chk(o_socket_power_down, 8'h03);
    i_power_down_req = 2'h0;
    acc(1'h1, 1'h0, 8'h92, 8'hA6);
    chk(o_low_voltage_capable, 8'h00);
    acc(1'h1, 1'h1, 8'h92, 8'h66);
    chk(o_low_voltage_capable, 8'h00);
    $display("Test done: priority, power, globals");
    i_rstn = 1'h0;
    step(6);
    chk({o_low_voltage_capable, o_intr_mode_f0, o_video_select_socket_a_n,
      o_video_select_socket_b_n}, {3'h0, 1'h1, sccr_pkg::SCCR_MODE_SERIAL, 2'h3});
    chk({o_ring_indicate_output, o_ring_indicate_output_oe}, 8'h00);
    i_rstn = 1'h1;
    acc(1'h0, 1'h0, 8'h92, 8'h66);
    acc(1'h0, 1'h1, 8'h91, 8'h00);
    $display("Test done: reset values");
    complete_run;
  end
endmodule : tb
